// file: asfr_adc_model.sv
// asfr_adc_model: behavioural converter on the far side of the link.
// assumes frame and clock move only on the host's clock edges.
`timescale 1ns/1ps
`default_nettype none
module asfr_adc_model (
  input wire logic shiftClock, // serial clock
  input wire logic frameN, // chip-select
  input wire logic [15:0] word, // word to shift out
  output logic dataOut, // serial result
  output logic poweredDown // power-down entered
);
  int idx = 0;
  int falls = 0;
  initial begin
    dataOut = 1'b0;
    poweredDown = 1'b0;
  end
  always @(negedge frameN) begin
    idx = 15;
    falls = 0;
    poweredDown = 1'b0;
    dataOut = word[15];
  end
  always @(negedge shiftClock) begin
    if (!frameN) begin
      falls++;
      idx--;
      dataOut = (idx >= 0) ? word[idx] : ~dataOut;
    end
  end
  // released line shows a changed level, never the last bit
  always @(posedge frameN) begin
    poweredDown = (falls >= 2 && falls <= 10);
    dataOut = ~dataOut;
  end
endmodule : asfr_adc_model
`default_nettype wire

// file: asfr_host.sv
// asfr_host: host serial port that runs the converter frames and collects words.
// assumes the converter result input is stable around serial clock falling edges.
//
// How it works
// RULE1: serial clock free-running, frame generated internally
// RULE2: full frame is sixteen serial clocks
// RULE3: ten-bit word keeps trailing zero padding
// RULE4: optional fourteen-clock frame for ten-bit part
// RULE5: power-down uses eight-clock short burst
// RULE6: frame output is active low
// RULE7: one frame per word, held whole word
// RULE8: received word stored right-justified
// RULE9: one frame times transmit and receive
// RULE10: serial clock divided from master clock
// RULE11: start after serial clock high, low, high
// RULE12: sample interval whole serial clock periods
// RULE13: frames issued at equal intervals
// RULE14: shared clock and frame, normal mode
// RULE15: negative frame sync starts conversion
// RULE16: received data assembled MSB first
// RULE17: converter samples at chip-select fall
// RULE18: converter shifts bits on falling edges
// RULE19: early chip-select rise aborts conversion
// RULE20: chip-select rise edges two-ten powers down
// RULE21: idle after reset, partial words discarded
// RULE22: one sample per clock, valid flag
`timescale 1ns/1ps
`default_nettype none
module asfr_host (
  input wire logic mclk, // 100 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic shiftClock, // serial clock to converter
  output logic frameN, // tx frame, also chip-select, active low
  input wire logic serialResultOut // converter data line
);
  asfr_pkg::asfr_state_e state_q, state_d;
  logic [3:0] ctrl_q;
  logic [15:0] div_q, period_q;
  logic [15:0] divCnt_q, perCnt_q;
  logic [4:0] bitCnt_q, frameLen_q;
  logic [15:0] shift_q, result_q;
  logic valid_q, overrun_q, pending_q;
  logic [1:0] alignStep_q;
  asfr_pkg::asfr_link_s link_q;
  logic awHeld_q, wHeld_q;
  asfr_pkg::asfr_wreq_s wreq_q;
  logic [3:0] wstrb_q;

  // bus decode
  wire doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  wire doRead = s_axi_arvalid && s_axi_arready;
  wire rdResult = doRead && (s_axi_araddr == asfr_pkg::OFF_RESULT);
  wire wrCtrl = doWrite && (wreq_q.addr == asfr_pkg::OFF_CTRL) && wstrb_q[0];
  wire wrDiv = doWrite && (wreq_q.addr == asfr_pkg::OFF_DIV);
  wire wrPer = doWrite && (wreq_q.addr == asfr_pkg::OFF_PERIOD);
  wire wrHit = wrCtrl || wrDiv || wrPer || (wreq_q.addr == asfr_pkg::OFF_CTRL);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // serial clock divider: toggle each div_q+1 master clocks
  wire divWrap = (divCnt_q == div_q); // RULE10
  wire sclkFall = divWrap && link_q.sclk;
  wire sclkRise = divWrap && !link_q.sclk;
  // sample timer counted in whole serial clock periods
  wire tick = sclkRise && (perCnt_q == period_q); // RULE12 RULE13
  wire enabled = ctrl_q[asfr_pkg::CTRL_ENABLE];
  wire [4:0] lenSel = ctrl_q[asfr_pkg::CTRL_POWERDOWN] ? asfr_pkg::LEN_PDOWN : // RULE5
                      ctrl_q[asfr_pkg::CTRL_SHORT] ? asfr_pkg::LEN_SHORT : // RULE4
                      asfr_pkg::LEN_FULL; // RULE2 RULE3
  wire lastBit = sclkFall && (bitCnt_q == frameLen_q - 5'd1);
  wire wordDone = lastBit && (frameLen_q != asfr_pkg::LEN_PDOWN);
  wire [15:0] shiftNext = {shift_q[14:0], serialResultOut}; // RULE16

  always_comb begin
    state_d = state_q;
    case (state_q)
      asfr_pkg::ST_IDLE: begin
        if (pending_q) state_d = asfr_pkg::ST_ALIGN; // RULE21
      end
      asfr_pkg::ST_ALIGN: begin
        if (alignStep_q == 2'd2 && sclkRise) state_d = asfr_pkg::ST_FRAME; // RULE11
      end
      asfr_pkg::ST_FRAME: begin
        if (lastBit) state_d = asfr_pkg::ST_IDLE; // RULE7
      end
      default: state_d = asfr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 16'h0000;
      link_q <= '{sclk: 1'b0, frameN: 1'b1};
    end else begin
      divCnt_q <= divWrap ? 16'h0000 : divCnt_q + 16'h0001;
      if (divWrap) link_q.sclk <= ~link_q.sclk; // RULE1 RULE14
      // frame falls on a rising edge, rises with the last falling edge
      if (state_q == asfr_pkg::ST_ALIGN && state_d == asfr_pkg::ST_FRAME)
        link_q.frameN <= 1'b0; // RULE6 RULE15 RULE9 RULE17
      else if (lastBit)
        link_q.frameN <= 1'b1; // RULE19 RULE20
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= asfr_pkg::ST_IDLE;
      perCnt_q <= 16'h0000;
      pending_q <= 1'b0;
      alignStep_q <= 2'd0;
      bitCnt_q <= 5'd0;
      frameLen_q <= asfr_pkg::LEN_FULL;
      shift_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (sclkRise) perCnt_q <= tick ? 16'h0000 : perCnt_q + 16'h0001;
      if (tick && enabled) pending_q <= 1'b1;
      else if (wrCtrl && wreq_q.data[asfr_pkg::CTRL_ONESHOT]) pending_q <= 1'b1;
      else if (state_q == asfr_pkg::ST_ALIGN && state_d == asfr_pkg::ST_FRAME) pending_q <= 1'b0;
      // high, low, high seen on the serial clock
      if (state_q != asfr_pkg::ST_ALIGN) alignStep_q <= 2'd0;
      else if (alignStep_q == 2'd0 && sclkRise) alignStep_q <= 2'd1;
      else if (alignStep_q == 2'd1 && sclkFall) alignStep_q <= 2'd2; // RULE11
      if (state_d == asfr_pkg::ST_FRAME && state_q == asfr_pkg::ST_ALIGN) begin
        bitCnt_q <= 5'd0;
        frameLen_q <= lenSel;
        shift_q <= 16'h0000; // RULE21
      end else if (state_q == asfr_pkg::ST_FRAME && sclkFall) begin
        bitCnt_q <= bitCnt_q + 5'd1;
        shift_q <= shiftNext; // RULE18 RULE22
      end
    end
  end

  // result register, right-justified with zero fill
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_q <= 16'h0000;
      valid_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (wordDone) result_q <= (frameLen_q == asfr_pkg::LEN_SHORT) ?
                                 {2'b00, shiftNext[13:0]} : shiftNext; // RULE8 RULE3
      if (wordDone) valid_q <= 1'b1; // RULE22
      else if (rdResult) valid_q <= 1'b0;
      if (wordDone && valid_q && !rdResult) overrun_q <= 1'b1;
      else if (rdResult) overrun_q <= 1'b0;
    end
  end

  // AXI4-Lite slave
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wreq_q <= '0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= asfr_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= asfr_pkg::RESP_OKAY;
      ctrl_q <= asfr_pkg::CTRL_RST;
      div_q <= asfr_pkg::DIV_RST;
      period_q <= asfr_pkg::PERIOD_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        wreq_q.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wreq_q.data <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? asfr_pkg::RESP_OKAY : asfr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wrCtrl) ctrl_q <= {1'b0, wreq_q.data[2:0]};
      if (wrDiv) div_q <= merge16(div_q, wreq_q.data, wstrb_q);
      if (wrPer) period_q <= merge16(period_q, wreq_q.data, wstrb_q);
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= asfr_pkg::RESP_OKAY;
        case (s_axi_araddr)
          asfr_pkg::OFF_CTRL: s_axi_rdata <= {28'h000_0000, ctrl_q};
          asfr_pkg::OFF_DIV: s_axi_rdata <= {16'h0000, div_q};
          asfr_pkg::OFF_PERIOD: s_axi_rdata <= {16'h0000, period_q};
          asfr_pkg::OFF_RESULT: s_axi_rdata <= {valid_q, overrun_q, 14'h0000, result_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= asfr_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign shiftClock = link_q.sclk;
  assign frameN = link_q.frameN;
endmodule : asfr_host
`default_nettype wire

// file: asfr_host_properties.sv
// asfr_host_properties: temporal checks on the readout host ports.
// assumes one clock domain; bound to asfr_host at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module asfr_host_properties (
  input wire logic mclk, // clock
  input wire logic rst, // async reset
  input wire logic shiftClock, // serial clock
  input wire logic frameN, // frame, active low
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic sclkQ;
  logic [4:0] fallCnt;
  // falls seen inside the frame; the closing fall is not counted
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclkQ <= 1'b0;
      fallCnt <= 5'd0;
    end else begin
      sclkQ <= shiftClock;
      fallCnt <= frameN ? 5'd0 : fallCnt + 5'(sclkQ & ~shiftClock);
    end
  end
  AST_FRAME_START: assert property ($fell(frameN) |-> $rose(shiftClock))
    else $error("frame fell off a clock rise");
  AST_FRAME_END: assert property ($rose(frameN) |-> $fell(shiftClock))
    else $error("frame rose off a clock fall");
  AST_FRAME_LEN: assert property ($rose(frameN) |-> fallCnt inside {5'd15, 5'd13, 5'd7})
    else $error("bad frame length");
  AST_RESET_IDLE: assert property ($fell(rst) |-> frameN && !shiftClock)
    else $error("link not idle after reset");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_RELEASE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after response taken");
  cover property ($rose(frameN) && fallCnt == 5'd15);
  cover property ($rose(frameN) && fallCnt == 5'd13);
  cover property ($rose(frameN) && fallCnt == 5'd7);
endmodule : asfr_host_properties
bind asfr_host asfr_host_properties chk (.*);
`default_nettype wire

// file: asfr_host_tb.sv
// asfr_host_tb: self-checking bench for the converter readout host.
// assumes the converter model and the property checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module asfr_host_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wr, bv, arr, rv, sclk, frameN, sdo, pd;
  logic [1:0] bresp, rresp;
  logic [15:0] word = '0;
  logic [15:0] lastRes = '0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] expQ[$];
  int errors = 0;
  int num_checks = 0;
  asfr_host DUT (.mclk, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .shiftClock(sclk), .frameN,
    .serialResultOut(sdo));
  asfr_adc_model conv (.shiftClock(sclk), .frameN, .word, .dataOut(sdo), .poweredDown(pd));
  initial forever #5 mclk = ~mclk;
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa = 1, pw = 1;
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (pa && awr) begin pa = 0; awv <= 0; end
      if (pw && wr) begin pw = 0; wv <= 0; end
    end while (!bv);
    bready <= 0;
    `CHK(bresp, er)
    @(posedge mclk);
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arv && arr) arv <= 0;
    end while (!rv);
    rready <= 0;
    `CHK(rdata, e)
    `CHK(rresp, er)
    @(posedge mclk);
  endtask : axr
  task automatic wait_frame;
    int n = 0;
    while (frameN !== 1'b0 && n < 500) begin @(posedge mclk); n++; end
    while (frameN !== 1'b1 && n < 500) begin @(posedge mclk); n++; end
  endtask : wait_frame
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    logic [3:0] ctrl;
    time t0;
    repeat (16) @(posedge mclk);
    rst <= 0;
    d = $urandom(32'h0e20_50c4);
    @(posedge mclk);
    `CHK(frameN, 1'b1)
    axr(asfr_pkg::OFF_CTRL, {28'h0, asfr_pkg::CTRL_RST}, asfr_pkg::RESP_OKAY);
    axr(asfr_pkg::OFF_DIV, {16'h0, asfr_pkg::DIV_RST}, asfr_pkg::RESP_OKAY);
    axr(asfr_pkg::OFF_PERIOD, {16'h0, asfr_pkg::PERIOD_RST}, asfr_pkg::RESP_OKAY);
    axr(4'h2, 32'h0, asfr_pkg::RESP_SLVERR);
    axw(4'h6, 32'h1, asfr_pkg::RESP_SLVERR);
    // only the upper byte lane is enabled, so the low byte keeps its reset value
    wstrb <= 4'h2;
    axw(asfr_pkg::OFF_DIV, 32'h0000_0009, asfr_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axr(asfr_pkg::OFF_DIV, {16'h0, asfr_pkg::DIV_RST}, asfr_pkg::RESP_OKAY);
    axw(asfr_pkg::OFF_DIV, 32'h1, asfr_pkg::RESP_OKAY);
    @(posedge sclk) t0 = $time;
    @(posedge sclk);
    `CHK($time - t0, 64'd40)
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      d = $urandom();
      @(posedge mclk);
      word <= (k == 1 || k == 2) ? {4'h0, d[9:0], 2'b00} : {4'h0, d[11:0]};
      ctrl = '0;
      ctrl[asfr_pkg::CTRL_ONESHOT] = 1'b1;
      ctrl[asfr_pkg::CTRL_SHORT] = (k == 2);
      ctrl[asfr_pkg::CTRL_POWERDOWN] = (k == 3);
      axw(asfr_pkg::OFF_CTRL, {28'h0, ctrl}, asfr_pkg::RESP_OKAY);
      wait_frame();
      // a power-down burst stores nothing: the last word stays, flags already cleared
      expQ.push_back(k == 3 ? {16'h0000, lastRes} : {16'h8000, 16'(k == 2 ? word >> 2 : word)});
      lastRes = expQ[0][15:0];
      axr(asfr_pkg::OFF_RESULT, expQ.pop_front(), asfr_pkg::RESP_OKAY);
      `CHK(pd, 1'(k == 3))
      $display("test frame mode %0d done", k);
    end
    axw(asfr_pkg::OFF_PERIOD, 32'd20, asfr_pkg::RESP_OKAY);
    axw(asfr_pkg::OFF_CTRL, 32'h1, asfr_pkg::RESP_OKAY);
    @(negedge frameN) t0 = $time;
    @(negedge frameN);
    `CHK($time - t0, 64'd840)
    wait_frame();
    axw(asfr_pkg::OFF_CTRL, 32'h0, asfr_pkg::RESP_OKAY);
    axr(asfr_pkg::OFF_RESULT, {16'hC000, word}, asfr_pkg::RESP_OKAY);
    $display("test periodic done");
    give_verdict();
  end
endmodule : asfr_host_tb
`default_nettype wire

// file: asfr_pkg.sv
// asfr_pkg: constants and carrier types for the serial converter readout host.
// assumes a 32-bit AXI4-Lite control bus and one 100 MHz clock.
package asfr_pkg;
  // control register map (byte addresses)
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_DIV = 4'h4;
  localparam logic [3:0] OFF_PERIOD = 4'h8;
  localparam logic [3:0] OFF_RESULT = 4'hC;
  // control and result fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_SHORT = 1;
  localparam int CTRL_POWERDOWN = 2;
  localparam int CTRL_ONESHOT = 3;
  localparam int RES_VALID = 31;
  localparam int RES_OVERRUN = 30;
  // frame lengths in serial clocks
  localparam logic [4:0] LEN_FULL = 5'd16;
  localparam logic [4:0] LEN_SHORT = 5'd14;
  localparam logic [4:0] LEN_PDOWN = 5'd8;
  // reset values and bus response codes
  localparam logic [15:0] DIV_RST = 16'h0004;
  localparam logic [15:0] PERIOD_RST = 16'h0020;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ALIGN = 2'b01,
    ST_FRAME = 2'b10
  } asfr_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] data;
  } asfr_wreq_s;

  typedef struct packed {
    logic sclk;
    logic frameN;
  } asfr_link_s;
endpackage : asfr_pkg
